//--- hdl/itc_pkg.sv
// package: register map, field positions, reset values for the interrupt and timer control block
package itc_pkg;

	// ==========================================================
	// register indices; byte address is four times the index
	// ==========================================================
	localparam logic [5:0] IDX_SHIFT_BUF = 6'h0C;	// serial_shift_buffer
	localparam logic [5:0] IDX_INT_FLAGS = 6'h0D;	// interrupt_flags_and_mask
	localparam logic [5:0] IDX_CTL_A     = 6'h0E;	// timer_a_control
	localparam logic [5:0] IDX_CTL_B     = 6'h0F;	// timer_b_control
	localparam logic [5:0] IDX_LATCH_A   = 6'h10;	// timer a reload latch, 16 bits
	localparam logic [5:0] IDX_LATCH_B   = 6'h11;	// timer b reload latch, 16 bits

	// ==========================================================
	// interrupt flag and mask fields
	// ==========================================================
	localparam int EV_TA       = 0;	// timer_a_underflow
	localparam int EV_TB       = 1;	// timer_b_underflow
	localparam int EV_ALARM    = 2;	// alarm_match_event
	localparam int EV_SERIAL   = 3;	// serial_port_event
	localparam int EV_FLAG     = 4;	// external_flag_event
	localparam int NUM_EVENTS  = 5;	// number of interrupt sources
	localparam int SUMMARY_BIT = 7;	// any_enabled_pending, also set/clear on writes

	// ==========================================================
	// control register fields
	// ==========================================================
	localparam int CTL_START  = 0;	// run the timer
	localparam int CTL_ROUTE  = 1;	// port_output_route
	localparam int CTL_STYLE  = 2;	// output_style, 1 toggle
	localparam int CTL_RUN    = 3;	// run_style, 1 one-shot
	localparam int CTL_LOAD   = 4;	// force load strobe, never stored
	localparam int CTL_SRC_LO = 5;	// count_source low bit
	localparam int CTL_SRC_HI = 6;	// timer b count_source high bit / timer a serial_direction
	localparam int CTL_TOP    = 7;	// timer a rate select, timer b alarm write select

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [7:0]  CTL_RESET   = 8'h00;	// timers stopped, pulse, continuous
	localparam logic [4:0]  MASK_RESET  = 5'h00;	// all sources masked off
	localparam logic [15:0] LATCH_RESET = 16'hFFFF;	// longest period

	// ==========================================================
	// timer b count source encodings
	// ==========================================================
	localparam logic [1:0] SRC_CLOCK    = 2'h0;	// system clock cycles
	localparam logic [1:0] SRC_PIN      = 2'h1;	// rising count_pin edges
	localparam logic [1:0] SRC_TA       = 2'h2;	// timer a underflows
	localparam logic [1:0] SRC_TA_GATED = 2'h3;	// timer a underflows while count_pin high

	localparam int BYTE_BITS = 8;	// serial byte length

endpackage

//--- hdl/itc_timer.sv
// file: one down counter with reload latch, run control and port output shaping
`timescale 1ns/1ps
`default_nettype none

module itc_timer #(
	parameter int W = 16	// counter width
) (
	input  wire logic         hclk,		// system clock
	input  wire logic         hresetn,	// async reset, active low
	input  wire logic         ce,		// clock enable
	input  wire logic         start,	// run bit from control register
	input  wire logic         run_style,	// 1 one-shot
	input  wire logic         output_style,	// 1 toggle, 0 pulse
	input  wire logic         force_load,	// one-cycle load strobe
	input  wire logic         tick,		// count qualifier
	input  wire logic [W-1:0] latch,	// reload value
	output logic              underflow,	// one-cycle pulse per underflow
	output logic              stop_req,	// one-shot end, clears run bit
	output logic              port_out	// shaped output for the port line
);

	logic [W-1:0] count_q;	// live counter
	logic         uf_q;	// registered underflow pulse
	logic         tog_q;	// toggle style level
	logic         start_q;	// run bit one cycle ago

	// a one-shot end halts counting in the cycle before the run bit drops, so the counter rests on the latch value
	wire wrap = start && !stop_req && tick && (count_q == '0);	// counter reaches the end

	// ==========================================================
	// counter: force load beats counting
	// ==========================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= '1;
		end else if (ce) begin
			if (force_load) begin
				count_q <= latch;
			end else if (wrap) begin
				count_q <= latch;
			end else if (start && !stop_req && tick) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	// ==========================================================
	// underflow pulse and one-shot stop
	// ==========================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			uf_q     <= 1'b0;
			stop_req <= 1'b0;
		end else if (ce) begin
			uf_q     <= wrap;
			stop_req <= wrap && run_style;
		end
	end

	// ==========================================================
	// toggle level: high on start, inverts per underflow
	// ==========================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tog_q   <= 1'b0;
			start_q <= 1'b0;
		end else if (ce) begin
			start_q <= start;
			if (start && !start_q) begin
				tog_q <= 1'b1;
			end else if (wrap) begin
				tog_q <= !tog_q;
			end
		end
	end

	assign underflow = uf_q;
	assign port_out  = output_style ? tog_q : uf_q;

	// pulse style gives exactly one cycle high per underflow
	pulse_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && uf_q && !output_style && !$past(uf_q)) |=> (!uf_q || !ce || $past(wrap)))
		else $error("pulse output longer than one cycle without a new underflow");

endmodule
`default_nettype wire

//--- hdl/itc_core.sv
// file: interrupt aggregation, timer and serial control with an ahb-lite register slave
// Operation
// - serial bytes go most significant bit first
// - idle data line holds last sent bit
// - clock and data lines only pull low
// - five interrupt sources accepted
// - every event sets its flag regardless of mask
// - enabled event sets summary, drives request low
// - flag read clears all, releases request
// - mask write top zero clears ones
// - mask write top one sets ones
// - bit 0 runs timer, one-shot clears it
// - timer a route drives port line six
// - bit 2 picks toggle or pulse output
// - bit 3 picks one-shot or continuous
// - bit 4 strobes force load, reads zero
// - timer a counts clocks or pin edges
// - timer a bit 6 sets serial direction
// - timer a bit 7 picks 50/60 Hz
// - timer b low bits mirror timer a
// - timer b bits 6,5 pick count source
// - timer b bit 7 steers clock writes
// - unimplemented bits ignore writes, read zero
// - one-shot stops after reload, continuous repeats
// - force load copies latch any time
// - pulse one cycle; toggle starts high, resets low
`timescale 1ns/1ps
`default_nettype none

module itc_core #(
	parameter int TW = 16	// timer width
) (
	input  wire logic        hclk,			// system clock, 100 MHz
	input  wire logic        hresetn,		// async reset, active low
	input  wire logic        ce,			// clock enable, freezes all state
	input  wire logic        hsel,			// slave select
	input  wire logic [31:0] haddr,			// byte address
	input  wire logic [1:0]  htrans,		// transfer type
	input  wire logic        hwrite,		// write when high
	input  wire logic [2:0]  hsize,			// transfer size
	input  wire logic        hready,		// bus ready in
	input  wire logic [31:0] hwdata,		// write data
	output logic [31:0]      hrdata,		// read data
	output logic             hreadyout,		// always ready
	output logic             hresp,			// always okay
	output logic             irq_n,			// interrupt request, active low
	input  wire logic        count_pin_in,		// count_pin level seen on the wire
	output logic             count_pin_out,		// count_pin drive value, low only
	output logic             count_pin_oe,		// count_pin pull-down enable
	input  wire logic        serial_in,		// serial data level seen on the wire
	output logic             serial_out,		// serial data drive value, low only
	output logic             serial_oe,		// serial data pull-down enable
	input  wire logic        alarm_match_event,	// one-cycle alarm pulse
	input  wire logic        external_flag_event,	// one-cycle flag pulse
	output logic             port_b_line_six,	// timer a shaped output
	output logic             port_b_line_six_oe,	// timer a owns line six
	output logic             port_b_line_seven,	// timer b shaped output
	output logic             port_b_line_seven_oe,	// timer b owns line seven
	output logic             time_of_day_input_rate,// 1 for 50 Hz, 0 for 60 Hz
	output logic             tod_write_alarm	// clock writes go to alarm
);

	// ==========================================================
	// declarations
	// ==========================================================
	logic          wr_pend_q;	// write data phase pending
	logic [5:0]    wr_idx_q;	// word index of pending write
	logic [7:0]    rd_q;		// registered read data
	logic [7:0]    ctl_a_q;		// timer_a_control storage
	logic [7:0]    ctl_b_q;		// timer_b_control storage
	logic [TW-1:0] latch_a_q;	// timer a reload latch
	logic [TW-1:0] latch_b_q;	// timer b reload latch
	logic [4:0]    flags_q;		// sticky event flags
	logic [4:0]    mask_q;		// interrupt enables
	logic          summary_q;	// any_enabled_pending
	logic [7:0]    buf_q;		// serial_shift_buffer
	logic          buf_full_q;	// output byte waiting
	logic [7:0]    shift_q;		// shift register
	logic [3:0]    bits_q;		// bits moved in the current byte
	logic          tx_active_q;	// output transfer running
	logic          clk_line_q;	// our shift clock level
	logic          data_line_q;	// our data level
	logic          pin_prev_q;	// count_pin one cycle ago
	logic          serial_ev_q;	// serial byte done pulse
	logic          ta_uf;		// timer a underflow
	logic          tb_uf;		// timer b underflow
	logic          ta_stop;		// timer a one-shot end
	logic          tb_stop;		// timer b one-shot end
	logic          ta_port;		// timer a port output
	logic          tb_port;		// timer b port output
	logic          tb_tick;		// timer b count qualifier
	logic [4:0]    events;		// this cycle's events

	wire       addr_ok  = hsel && hready && htrans[1];	// address phase accepted
	wire [5:0] addr_idx = haddr[7:2];			// word index
	wire       rd_take  = ce && addr_ok && !hwrite;		// read taken
	wire       rd_flags = rd_take && (addr_idx == itc_pkg::IDX_INT_FLAGS);	// clearing read
	wire       wr_now   = ce && wr_pend_q;			// write data phase
	wire [7:0] wb       = hwdata[7:0];			// written byte
	wire       pin_rise = count_pin_in && !pin_prev_q;	// rising count_pin edge
	wire       ser_out  = ctl_a_q[itc_pkg::CTL_SRC_HI];	// serial_direction
	wire       ld_a     = wr_now && (wr_idx_q == itc_pkg::IDX_CTL_A) && wb[itc_pkg::CTL_LOAD];
	wire       ld_b     = wr_now && (wr_idx_q == itc_pkg::IDX_CTL_B) && wb[itc_pkg::CTL_LOAD];
	wire [1:0] src_b    = ctl_b_q[itc_pkg::CTL_SRC_HI:itc_pkg::CTL_SRC_LO];	// timer b source

	// ==========================================================
	// bus slave: zero wait, address phase captured for writes
	// ==========================================================
	assign hreadyout = 1'b1;	// no wait states
	assign hresp     = 1'b0;	// always okay

	// write address capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 6'h00;
		end else if (ce) begin
			if (hready) begin
				wr_pend_q <= addr_ok && hwrite;
				wr_idx_q  <= addr_idx;
			end
		end
	end

	// read data is picked at the address phase so the flag read and its clear line up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 8'h00;
		end else if (rd_take) begin
			case (addr_idx)
				itc_pkg::IDX_SHIFT_BUF: rd_q <= buf_q;
				itc_pkg::IDX_INT_FLAGS: rd_q <= {summary_q, 2'b00, flags_q};
				itc_pkg::IDX_CTL_A:     rd_q <= ctl_a_q;
				itc_pkg::IDX_CTL_B:     rd_q <= ctl_b_q;
				itc_pkg::IDX_LATCH_A:   rd_q <= latch_a_q[7:0];
				itc_pkg::IDX_LATCH_B:   rd_q <= latch_b_q[7:0];
				default:                rd_q <= 8'h00;	// unmapped reads zero
			endcase
		end
	end

	// latches expose only their low byte on reads; upper bits are write side
	assign hrdata = {24'h000000, rd_q};

	// ==========================================================
	// control registers; the load bit is never stored
	// ==========================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_a_q <= itc_pkg::CTL_RESET;
		end else if (ce) begin
			if (wr_now && (wr_idx_q == itc_pkg::IDX_CTL_A)) begin
				ctl_a_q <= wb & 8'hEF;
			end else if (ta_stop) begin
				ctl_a_q[itc_pkg::CTL_START] <= 1'b0;
			end
		end
	end

	// timer b control, same layout in the low bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_b_q <= itc_pkg::CTL_RESET;
		end else if (ce) begin
			if (wr_now && (wr_idx_q == itc_pkg::IDX_CTL_B)) begin
				ctl_b_q <= wb & 8'hEF;
			end else if (tb_stop) begin
				ctl_b_q[itc_pkg::CTL_START] <= 1'b0;
			end
		end
	end

	// reload latches
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_a_q <= itc_pkg::LATCH_RESET[TW-1:0];
			latch_b_q <= itc_pkg::LATCH_RESET[TW-1:0];
		end else if (wr_now) begin
			if (wr_idx_q == itc_pkg::IDX_LATCH_A) begin
				latch_a_q <= hwdata[TW-1:0];
			end
			if (wr_idx_q == itc_pkg::IDX_LATCH_B) begin
				latch_b_q <= hwdata[TW-1:0];
			end
		end
	end

	// ==========================================================
	// timers
	// ==========================================================
	// timer b source select; the gated mode samples the pin level
	always_comb begin
		case (src_b)
			itc_pkg::SRC_CLOCK:    tb_tick = 1'b1;
			itc_pkg::SRC_PIN:      tb_tick = pin_rise;
			itc_pkg::SRC_TA:       tb_tick = ta_uf;
			itc_pkg::SRC_TA_GATED: tb_tick = ta_uf && count_pin_in;
			default:               tb_tick = 1'b0;
		endcase
	end

	itc_timer #(.W(TW)) u_timer_a (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.ce           (ce),
		.start        (ctl_a_q[itc_pkg::CTL_START]),
		.run_style    (ctl_a_q[itc_pkg::CTL_RUN]),
		.output_style (ctl_a_q[itc_pkg::CTL_STYLE]),
		.force_load   (ld_a),
		.tick         (ctl_a_q[itc_pkg::CTL_SRC_LO] ? pin_rise : 1'b1),
		.latch        (latch_a_q),
		.underflow    (ta_uf),
		.stop_req     (ta_stop),
		.port_out     (ta_port)
	);

	itc_timer #(.W(TW)) u_timer_b (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.ce           (ce),
		.start        (ctl_b_q[itc_pkg::CTL_START]),
		.run_style    (ctl_b_q[itc_pkg::CTL_RUN]),
		.output_style (ctl_b_q[itc_pkg::CTL_STYLE]),
		.force_load   (ld_b),
		.tick         (tb_tick),
		.latch        (latch_b_q),
		.underflow    (tb_uf),
		.stop_req     (tb_stop),
		.port_out     (tb_port)
	);

	// port lines and plain control outputs
	assign port_b_line_six        = ta_port;
	assign port_b_line_six_oe     = ctl_a_q[itc_pkg::CTL_ROUTE];
	assign port_b_line_seven      = tb_port;
	assign port_b_line_seven_oe   = ctl_b_q[itc_pkg::CTL_ROUTE];
	assign time_of_day_input_rate = ctl_a_q[itc_pkg::CTL_TOP];
	assign tod_write_alarm        = ctl_b_q[itc_pkg::CTL_TOP];

	// ==========================================================
	// serial port: output shifts on timer a underflows, input on pin edges
	// ==========================================================
	// pin history for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_prev_q <= 1'b1;
		end else if (ce) begin
			pin_prev_q <= count_pin_in;
		end
	end

	// shift engine; two underflows make one bit, so the bit rate is half the underflow rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q     <= 8'h00;
			bits_q      <= 4'h0;
			tx_active_q <= 1'b0;
			clk_line_q  <= 1'b1;
			data_line_q <= 1'b1;
			serial_ev_q <= 1'b0;
		end else if (ce) begin
			serial_ev_q <= 1'b0;
			if (ser_out) begin
				if (!tx_active_q) begin
					clk_line_q <= 1'b1;
					if (buf_full_q && ctl_a_q[itc_pkg::CTL_START] && !ctl_a_q[itc_pkg::CTL_RUN]) begin
						shift_q     <= buf_q;
						bits_q      <= 4'h0;
						tx_active_q <= 1'b1;
					end
				end else if (ta_uf) begin
					if (clk_line_q) begin
						// falling clock: next bit goes out, top bit first
						clk_line_q  <= 1'b0;
						data_line_q <= shift_q[7];
						shift_q     <= {shift_q[6:0], 1'b0};
					end else begin
						clk_line_q <= 1'b1;
						if (bits_q == 4'(itc_pkg::BYTE_BITS - 1)) begin
							serial_ev_q <= 1'b1;
							bits_q      <= 4'h0;
							if (buf_full_q) begin
								shift_q <= buf_q;	// back to back byte
							end else begin
								tx_active_q <= 1'b0;	// data line keeps last bit
							end
						end else begin
							bits_q <= bits_q + 4'h1;
						end
					end
				end
			end else begin
				// input: sample on rising external clock, top bit arrives first
				tx_active_q <= 1'b0;
				clk_line_q  <= 1'b1;
				data_line_q <= 1'b1;
				if (pin_rise) begin
					shift_q <= {shift_q[6:0], serial_in};
					if (bits_q == 4'(itc_pkg::BYTE_BITS - 1)) begin
						bits_q      <= 4'h0;
						serial_ev_q <= 1'b1;
					end else begin
						bits_q <= bits_q + 4'h1;
					end
				end
			end
		end
	end

	// buffer: host writes fill it, input mode dumps the received byte into it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_q      <= 8'h00;
			buf_full_q <= 1'b0;
		end else if (ce) begin
			if (wr_now && (wr_idx_q == itc_pkg::IDX_SHIFT_BUF)) begin
				buf_q      <= wb;
				buf_full_q <= ser_out;
			end else if (!ser_out && pin_rise && bits_q == 4'(itc_pkg::BYTE_BITS - 1)) begin
				buf_q <= {shift_q[6:0], serial_in};
			end else if (ser_out && buf_full_q && (!tx_active_q
				|| (ta_uf && !clk_line_q && bits_q == 4'(itc_pkg::BYTE_BITS - 1)))) begin
				buf_full_q <= !(ctl_a_q[itc_pkg::CTL_START] && !ctl_a_q[itc_pkg::CTL_RUN]) && !tx_active_q;
			end
		end
	end

	// open-drain lines: drive value is always low, enable only when we want low
	assign count_pin_out = 1'b0;
	assign serial_out    = 1'b0;
	assign count_pin_oe  = ser_out && !clk_line_q;
	assign serial_oe     = ser_out && !data_line_q;

	// ==========================================================
	// interrupt flags, mask and summary
	// ==========================================================
	assign events = {external_flag_event, serial_ev_q, alarm_match_event, tb_uf, ta_uf};

	// sticky flags: an event in the clearing cycle survives the read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q   <= 5'h00;
			summary_q <= 1'b0;
		end else if (ce) begin
			flags_q   <= (rd_flags ? 5'h00 : flags_q) | events;
			summary_q <= (rd_flags ? 1'b0 : summary_q) | (|(events & mask_q));
		end
	end

	// mask write: top bit chooses set or clear of the bits written as one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= itc_pkg::MASK_RESET;
		end else if (wr_now && (wr_idx_q == itc_pkg::IDX_INT_FLAGS)) begin
			if (wb[itc_pkg::SUMMARY_BIT]) begin
				mask_q <= mask_q | wb[4:0];
			end else begin
				mask_q <= mask_q & ~wb[4:0];
			end
		end
	end

	assign irq_n = !summary_q;

	// ==========================================================
	// checks
	// ==========================================================
	irq_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && |(events & mask_q)) |=> (!irq_n && summary_q))
		else $error("enabled event did not raise the request");

	flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_flags && events == 5'h00) |=> (flags_q == 5'h00 && irq_n))
		else $error("flag read did not clear flags and request");

	flag_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && events[itc_pkg::EV_FLAG]) |=> flags_q[itc_pkg::EV_FLAG])
		else $error("external flag event lost");

	flag_stay_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(flags_q[itc_pkg::EV_TA] && !rd_flags) |=> flags_q[itc_pkg::EV_TA])
		else $error("flag dropped without a read");

	mask_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && wr_idx_q == itc_pkg::IDX_INT_FLAGS && wb[7]) |=> ((mask_q & $past(wb[4:0])) == $past(wb[4:0])))
		else $error("mask set write failed");

	mask_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && wr_idx_q == itc_pkg::IDX_INT_FLAGS && !wb[7]) |=> ((mask_q & $past(wb[4:0])) == 5'h00))
		else $error("mask clear write failed");

	load_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctl_a_q[itc_pkg::CTL_LOAD] && !ctl_b_q[itc_pkg::CTL_LOAD])
		else $error("load bit was stored");

	oneshot_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && ta_stop && !wr_now) |=> !ctl_a_q[itc_pkg::CTL_START])
		else $error("one-shot underflow left timer running");

	flag_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && $past(rd_flags)) |-> (hrdata[6:5] == 2'b00))
		else $error("unused flag bits read nonzero");

endmodule
`default_nettype wire

//--- dv/itc_host.sv
// host master model: single word transfers on the register bus
`timescale 1ns/1ps
`default_nettype none
module itc_host (
	input  wire logic        hclk,	// system clock
	input  wire logic        hready,	// bus ready
	input  wire logic [31:0] hrdata,	// read data
	output logic      [31:0] haddr,	// byte address
	output logic      [1:0]  htrans,	// transfer type
	output logic             hwrite,	// write when high
	output logic      [31:0] hwdata	// write data
);
	// ==========
	// bus cycles
	// ==========
	initial begin
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end
	// call right after a rising edge; each phase held until ready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;	// released data must not look valid
	endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the interrupt and timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ==========
	// signals
	// ==========
	logic        hclk = 1'b0, hresetn = 1'b0, ready, hwrite, irq_n, cnt_oe, sp_oe;	// clock, reset, bus, pins
	logic        alarm = 1'b0, flag = 1'b0, pb6, pb6_oe, pb7, pb7_oe, rate, tod_alarm;	// events, port lines
	logic [31:0] haddr, hwdata, hrdata, q, seed = 32'hF326;	// bus and lfsr state
	logic [1:0]  htrans;	// transfer type
	int          failures = 0, comparisons = 0, exp_mask = 0, exp_flags = 0, n = 0;	// counters and model
	always #5 hclk = ~hclk;	// 100 MHz
	itc_host host_u (.hclk(hclk), .hready(ready), .hrdata(hrdata), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata));
	itc_core dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(ready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(ready),
		.hresp(), .irq_n(irq_n), .count_pin_in(~cnt_oe), .count_pin_out(), .count_pin_oe(cnt_oe),
		.serial_in(~sp_oe), .serial_out(), .serial_oe(sp_oe), .alarm_match_event(alarm),
		.external_flag_event(flag), .port_b_line_six(pb6), .port_b_line_six_oe(pb6_oe),
		.port_b_line_seven(pb7), .port_b_line_seven_oe(pb7_oe), .time_of_day_input_rate(rate),
		.tod_write_alarm(tod_alarm));
	// ==========
	// helpers
	// ==========
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge hclk);
		failures++;
		give_verdict();
	end
	// ==========
	// tests
	// ==========
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("reset outputs", 32'h10, {irq_n, pb6, pb7, pb6_oe, pb7_oe});
		for (int a = 'h34; a < 'h40; a += 4) begin
			host_u.xfer(1'b0, a[7:0], 32'h0, q);
			chk("reset read", 32'h0, q);
		end
		// random mask updates with events; flags must match the model
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			host_u.xfer(1'b1, 8'h34, seed, q);
			exp_mask = seed[7] ? (exp_mask | (seed & 32'h1F)) : (exp_mask & ~(seed & 32'h1F));
			alarm <= seed[8];
			flag <= seed[9];
			@(posedge hclk);
			alarm <= 1'b0;
			flag <= 1'b0;
			exp_flags = (seed[8] << 2) | (seed[9] << 4);
			if ((exp_flags & exp_mask) != 0) exp_flags |= 32'h80;
			@(posedge hclk);
			chk("irq_n", {31'h0, exp_flags < 32'h80}, {31'h0, irq_n});
			host_u.xfer(1'b0, 8'h34, 32'h0, q);
			chk("flags", exp_flags, q);
			host_u.xfer(1'b0, 8'h34, 32'h0, q);
			chk("flags cleared", 32'h0, q);
			chk("irq_n released", 32'h1, {31'h0, irq_n});
		end
		$display("mask and event test done");
		// control registers: load bit reads zero, upper bus bits ignored
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			host_u.xfer(1'b1, 8'h38, seed, q);
			host_u.xfer(1'b1, 8'h3C, seed >> 8, q);
			host_u.xfer(1'b0, 8'h38, 32'h0, q);
			chk("ctl a", seed & 32'hEF, q);
			host_u.xfer(1'b0, 8'h3C, 32'h0, q);
			chk("ctl b", (seed >> 8) & 32'hEF, q);
			chk("routes", {seed[15], seed[9], seed[7], seed[1]}, {tod_alarm, pb7_oe, rate, pb6_oe});
		end
		host_u.xfer(1'b0, 8'h80, 32'h0, q);
		chk("unmapped", 32'h0, q);
		$display("control test done");
		// timer a: one-shot of latch 3 gives one pulse and clears its run bit
		host_u.xfer(1'b1, 8'h40, 32'h3, q);
		host_u.xfer(1'b1, 8'h38, 32'h1B, q);	// start, route, one-shot, force load
		n = 0;
		repeat (20) begin
			@(posedge hclk);
			n += pb6;
		end
		chk("one-shot pulses", 32'h1, n);
		host_u.xfer(1'b0, 8'h38, 32'h0, q);
		chk("one-shot stop", 32'h0A, q);
		host_u.xfer(1'b0, 8'h34, 32'h0, q);
		chk("timer flag", exp_mask[0] ? 32'h81 : 32'h01, q);
		// continuous toggle: high on start, then half of every window of two periods
		host_u.xfer(1'b1, 8'h38, 32'h07, q);	// start, route, toggle, continuous
		repeat (2) @(posedge hclk);
		chk("toggle start", 32'h1, pb6);
		repeat (4) @(posedge hclk);
		n = 0;
		repeat (16) begin
			@(posedge hclk);
			n += pb6;
		end
		chk("toggle duty", 32'h8, n);
		host_u.xfer(1'b1, 8'h38, 32'h0, q);
		$display("timer test done");
		give_verdict();
	end
endmodule
`default_nettype wire
